// >>> hw/fpx_defines.svh
// Register offsets, field positions and reset values of the exception unit
`ifndef FPX_DEFINES_SVH
`define FPX_DEFINES_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FPX_OFF_STATUS   5'h00
`define FPX_OFF_BITSET   5'h04
`define FPX_OFF_MODE     5'h08
`define FPX_OFF_IRQ_STAT 5'h0C
`define FPX_OFF_IRQ_MASK 5'h10
`define FPX_OFF_INFO     5'h14
// ----------------------------------------
// Status register fields
// ----------------------------------------
`define FPX_NCOND        13
`define FPX_NEN          5
`define FPX_EN_LSB       16
`define FPX_INV_SUM_BIT  29
`define FPX_FEX_BIT      30
`define FPX_FX_BIT       31
// Condition bit positions
`define FPX_C_INEXACT    0
`define FPX_C_ZDIV       1
`define FPX_C_UNDER      2
`define FPX_C_OVER       3
`define FPX_C_SNAN       4
`define FPX_C_IMZ        8
`define FPX_C_VC         9
`define FPX_C_CVI        12
`define FPX_C_INV_LSB    4
// Enable bit positions
`define FPX_E_INV        4
// ----------------------------------------
// Interrupt status bits and reset values
// ----------------------------------------
`define FPX_IRQ_W        3
`define FPX_IRQ_DELIVER  0
`define FPX_IRQ_ILLEGAL  1
`define FPX_IRQ_SUPPRESS 2
`define FPX_RST_COND     13'h0000
`define FPX_RST_EN       5'h00
`define FPX_RST_MODE     2'h0
`define FPX_LAZY_CYCLES  8
`endif

// >>> hw/fpx_pkg.sv
// Types shared by the exception unit files
package fpx_pkg;
  typedef enum logic [1:0] {
    FPX_MODE_IGNORE  = 2'h0,
    FPX_MODE_IMP_NR  = 2'h1,
    FPX_MODE_IMP_REC = 2'h2,
    FPX_MODE_PRECISE = 2'h3
  } fpx_mode_t;

  typedef enum logic [1:0] {
    FPX_OP_OTHER = 2'h0,
    FPX_OP_FMA   = 2'h1,
    FPX_OP_CMPO  = 2'h2,
    FPX_OP_CVTI  = 2'h3
  } fpx_op_t;

  typedef enum logic [2:0] {
    FPX_ST_IDLE    = 3'h1,
    FPX_ST_PENDING = 3'h2,
    FPX_ST_DELIVER = 3'h4
  } fpx_state_t;
endpackage

// >>> hw/fpx_flag_update.sv
// Next-value logic of the sticky condition flags and summary flag
`include "fpx_defines.svh"
module fpx_flag_update (
  input  wire logic [`FPX_NCOND-1:0] cur_flags,
  input  wire logic                  cur_fx,
  input  wire logic                  ev_valid,
  input  wire logic [`FPX_NCOND-1:0] ev_flags,
  input  wire fpx_pkg::fpx_op_t      ev_op,
  input  wire logic                  sw_write,
  input  wire logic [`FPX_NCOND-1:0] sw_mask,
  input  wire logic [`FPX_NCOND-1:0] sw_data,
  input  wire logic                  sw_fx_we,
  input  wire logic                  sw_fx_data,
  input  wire logic                  sw_bitset,
  input  wire logic [`FPX_NCOND-1:0] sw_set,
  output logic      [`FPX_NCOND-1:0] flags_next,
  output logic                       fx_next,
  output logic                       illegal
);
  logic [`FPX_NCOND-1:0] ev_set;
  logic [`FPX_NCOND-1:0] sw_flags;
  logic [`FPX_NCOND-1:0] sw_rise;
  logic [`FPX_NCOND-1:0] pair_ok;
  logic                  fx_sw;

  assign ev_set = ev_valid ? ev_flags : '0;

  // ----------------------------------------
  // Software moves, then hardware sets
  // ----------------------------------------
  always_comb begin
    sw_flags = cur_flags;
    fx_sw    = cur_fx;
    if (sw_write) begin
      sw_flags = (cur_flags & ~sw_mask) | (sw_data & sw_mask);
      if (sw_fx_we) begin
        fx_sw = sw_fx_data;
      end
    end
    if (sw_bitset) begin
      sw_flags = cur_flags | sw_set;
    end
  end

  assign flags_next = sw_flags | ev_set;
  assign sw_rise    = (sw_write ? (sw_data & sw_mask) : '0) | (sw_bitset ? sw_set : '0);
  // summary on new or explicit set
  assign fx_next = fx_sw | (|(ev_set & ~cur_flags)) | (|(sw_rise & ~cur_flags))
                 | (sw_bitset & (|sw_set));

  // ----------------------------------------
  // Legal multi-flag combinations
  // ----------------------------------------
  // inexact pairs with over or under
  // signaling NaN pairs by op kind
  always_comb begin
    pair_ok = '0;
    pair_ok[`FPX_C_INEXACT] = 1'b1;
    pair_ok[`FPX_C_SNAN]    = 1'b1;
    pair_ok[`FPX_C_OVER]    = ev_set[`FPX_C_INEXACT];
    pair_ok[`FPX_C_UNDER]   = ev_set[`FPX_C_INEXACT];
    pair_ok[`FPX_C_IMZ]     = ev_set[`FPX_C_SNAN] && (ev_op == fpx_pkg::FPX_OP_FMA);
    pair_ok[`FPX_C_VC]      = ev_set[`FPX_C_SNAN] && (ev_op == fpx_pkg::FPX_OP_CMPO);
    pair_ok[`FPX_C_CVI]     = ev_set[`FPX_C_SNAN] && (ev_op == fpx_pkg::FPX_OP_CVTI);
  end

  assign illegal = ($countones(ev_set) > 1)
                && (($countones(ev_set) > 2) || (|(ev_set & ~pair_ok))
                    || (ev_set[`FPX_C_OVER] && ev_set[`FPX_C_UNDER]));
endmodule

// >>> hw/fpx_exception_control.sv
// Floating-point exception flags, trap modes and handler delivery
`include "fpx_defines.svh"
module fpx_exception_control #(
  parameter int TAG_W       = 8,
  parameter int LAZY_CYCLES = `FPX_LAZY_CYCLES
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic [4:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic                  ex_valid,
  input  wire logic [`FPX_NCOND-1:0] ex_flags,
  input  wire fpx_pkg::fpx_op_t      ex_op,
  input  wire logic [TAG_W-1:0]      ex_tag,
  input  wire logic                  sync_event,
  output logic                       ex_suppress,
  output logic                       ex_write_result,
  output logic      [`FPX_NEN-1:0]   ex_trap_result,
  output logic                       ex_hold_younger,
  output logic                       prog_exc,
  output logic      [TAG_W-1:0]      prog_exc_tag,
  output logic      [1:0]            prog_exc_mode,
  output logic                       irq
);
  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  if (TAG_W < 1 || TAG_W > 16) begin : g_bad_tag
    $error("TAG_W must be 1 to 16");
  end
  if (LAZY_CYCLES < 1 || LAZY_CYCLES > 255) begin : g_bad_lazy
    $error("LAZY_CYCLES must be 1 to 255");
  end

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Spread the five class enables over the condition bits
  function automatic logic [`FPX_NCOND-1:0] en_expand(input logic [`FPX_NEN-1:0] en);
    en_expand = {{(`FPX_NCOND-`FPX_C_INV_LSB){en[`FPX_E_INV]}}, en[`FPX_C_INV_LSB-1:0]};
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [`FPX_NCOND-1:0] cond_reg;
  logic [`FPX_NCOND-1:0] cond_next;
  logic                  fx_reg;
  logic                  fx_next;
  logic [`FPX_NEN-1:0]   en_reg;
  logic [1:0]            mode_reg;
  logic [`FPX_IRQ_W-1:0] irq_stat_reg;
  logic [`FPX_IRQ_W-1:0] irq_mask_reg;
  logic                  ack_reg;
  logic [31:0]           rdata_reg;
  logic                  fex_reg;
  logic [7:0]            lazy_reg;
  logic [TAG_W-1:0]      tag_reg;
  logic                  prog_exc_reg;
  logic [TAG_W-1:0]      prog_tag_reg;
  logic [1:0]            prog_mode_reg;
  fpx_pkg::fpx_state_t   state_reg;

  logic                  req;
  logic                  wr_acc;
  logic                  hit_status;
  logic                  hit_bitset;
  logic [31:0]           wmask;
  logic                  enabled_exception_summary;
  logic                  ex_en_hit;
  logic                  sw_fex_rise;
  logic                  trig;
  logic                  force_pend;
  logic                  illegal;
  logic                  mode_ignore;
  logic                  mode_precise;
  logic                  mode_imprecise;
  logic [`FPX_IRQ_W-1:0] irq_ev;
  logic [`FPX_IRQ_W-1:0] irq_w1c;

  // ----------------------------------------
  // Avalon-MM slave, one wait cycle
  // ----------------------------------------
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_reg;
  assign avs_readdata    = rdata_reg;
  assign wr_acc          = avs_write & ack_reg;
  assign wmask           = lane_mask(avs_byteenable);
  assign hit_status      = ack_reg && (avs_address == `FPX_OFF_STATUS);
  assign hit_bitset      = ack_reg && (avs_address == `FPX_OFF_BITSET);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // Read data captured in the wait cycle, stable at the accepting edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read & ~ack_reg) begin
      rdata_reg <= 32'h0000_0000;
      case (avs_address)
        `FPX_OFF_STATUS: begin
          rdata_reg[`FPX_NCOND-1:0]                    <= cond_reg;
          rdata_reg[`FPX_EN_LSB+`FPX_NEN-1:`FPX_EN_LSB] <= en_reg;
          rdata_reg[`FPX_INV_SUM_BIT] <= |cond_reg[`FPX_NCOND-1:`FPX_C_INV_LSB];
          rdata_reg[`FPX_FEX_BIT]     <= enabled_exception_summary;
          rdata_reg[`FPX_FX_BIT]      <= fx_reg;
        end
        `FPX_OFF_MODE:     rdata_reg[1:0] <= mode_reg;
        `FPX_OFF_IRQ_STAT: rdata_reg[`FPX_IRQ_W-1:0] <= irq_stat_reg;
        `FPX_OFF_IRQ_MASK: rdata_reg[`FPX_IRQ_W-1:0] <= irq_mask_reg;
        `FPX_OFF_INFO: begin
          rdata_reg[TAG_W-1:0] <= tag_reg;
          rdata_reg[18:16]     <= state_reg;
        end
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Flags and summaries
  // ----------------------------------------
  fpx_flag_update u_flags (
    .cur_flags  (cond_reg),
    .cur_fx     (fx_reg),
    .ev_valid   (ex_valid),
    .ev_flags   (ex_flags),
    .ev_op      (ex_op),
    .sw_write   (wr_acc & hit_status),
    .sw_mask    (wmask[`FPX_NCOND-1:0]),
    .sw_data    (avs_writedata[`FPX_NCOND-1:0]),
    .sw_fx_we   (wmask[`FPX_FX_BIT]),
    .sw_fx_data (avs_writedata[`FPX_FX_BIT]),
    .sw_bitset  (wr_acc & hit_bitset),
    .sw_set     (avs_writedata[`FPX_NCOND-1:0] & wmask[`FPX_NCOND-1:0]),
    .flags_next (cond_next),
    .fx_next    (fx_next),
    .illegal    (illegal)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cond_reg <= `FPX_RST_COND;
      fx_reg   <= 1'b0;
    end else begin
      cond_reg <= cond_next;
      fx_reg   <= fx_next;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      en_reg <= `FPX_RST_EN;
    end else if (wr_acc && hit_status && avs_byteenable[2]) begin
      en_reg <= avs_writedata[`FPX_EN_LSB+`FPX_NEN-1:`FPX_EN_LSB];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= `FPX_RST_MODE;
    end else if (wr_acc && avs_address == `FPX_OFF_MODE && avs_byteenable[0]) begin
      mode_reg <= avs_writedata[1:0];
    end
  end

  assign mode_ignore    = (mode_reg == fpx_pkg::FPX_MODE_IGNORE);
  assign mode_precise   = (mode_reg == fpx_pkg::FPX_MODE_PRECISE);
  assign mode_imprecise = ~mode_ignore & ~mode_precise;

  // enabled summary from flags and enables
  assign enabled_exception_summary = |(cond_reg & en_expand(en_reg));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fex_reg <= 1'b0;
    end else begin
      fex_reg <= enabled_exception_summary;
    end
  end

  // ----------------------------------------
  // Per-instruction result control
  // ----------------------------------------
  // disabled conditions never count
  assign ex_en_hit = ex_valid & (|(ex_flags & en_expand(en_reg)));

  assign ex_suppress = ex_valid
    & ((en_reg[`FPX_E_INV] & (|ex_flags[`FPX_NCOND-1:`FPX_C_INV_LSB]))
       | (en_reg[`FPX_C_ZDIV] & ex_flags[`FPX_C_ZDIV]));

  assign ex_write_result = ex_valid & ~ex_suppress;

  // per class, trap value when enabled
  assign ex_trap_result = ex_valid ? (en_reg & {|ex_flags[`FPX_NCOND-1:`FPX_C_INV_LSB],
                                                ex_flags[`FPX_C_INV_LSB-1:0]}) : '0;

  // ----------------------------------------
  // Handler delivery
  // ----------------------------------------
  // Software raising an enabled flag counts as a new enabled event
  assign sw_fex_rise = enabled_exception_summary & ~fex_reg;
  // needs an enabled hit or summary rise and a trapping mode
  assign trig        = (ex_en_hit | sw_fex_rise) & ~mode_ignore;
  // status access forces; so does sync
  assign force_pend  = mode_imprecise & (hit_status | hit_bitset | sync_event);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= fpx_pkg::FPX_ST_IDLE;
      lazy_reg  <= 8'h00;
      tag_reg   <= '0;
    end else begin
      case (state_reg)
        fpx_pkg::FPX_ST_IDLE: begin
          if (trig) begin
            tag_reg  <= ex_en_hit ? ex_tag : tag_reg;
            lazy_reg <= 8'(LAZY_CYCLES);
            if (mode_precise) begin
              state_reg <= fpx_pkg::FPX_ST_DELIVER;
            end else begin
              state_reg <= fpx_pkg::FPX_ST_PENDING;
            end
          end
        end
        fpx_pkg::FPX_ST_PENDING: begin
          // Held while ignore mode is set, dropped if software cleared it
          if (~enabled_exception_summary & ~ex_en_hit) begin
            state_reg <= fpx_pkg::FPX_ST_IDLE;
          end else if (mode_precise) begin
            state_reg <= fpx_pkg::FPX_ST_DELIVER;
          end else if (~mode_ignore) begin
            if (force_pend || lazy_reg == 8'h00) begin
              state_reg <= fpx_pkg::FPX_ST_DELIVER;
            end else begin
              lazy_reg <= lazy_reg - 8'h01;
            end
          end
        end
        fpx_pkg::FPX_ST_DELIVER: state_reg <= fpx_pkg::FPX_ST_IDLE;
        default:                 state_reg <= fpx_pkg::FPX_ST_IDLE;
      endcase
    end
  end

  // recoverable and precise stall younger consumers
  assign ex_hold_younger = (ex_en_hit & ~mode_ignore & ~(mode_reg == fpx_pkg::FPX_MODE_IMP_NR))
    | ((state_reg != fpx_pkg::FPX_ST_IDLE)
       & (mode_precise | (mode_reg == fpx_pkg::FPX_MODE_IMP_REC)));

  // raise with the tag of the excepting instruction
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prog_exc_reg  <= 1'b0;
      prog_tag_reg  <= '0;
      prog_mode_reg <= 2'h0;
    end else begin
      prog_exc_reg <= (state_reg == fpx_pkg::FPX_ST_DELIVER) & ~mode_ignore;
      if (state_reg == fpx_pkg::FPX_ST_DELIVER) begin
        prog_tag_reg  <= tag_reg;
        prog_mode_reg <= mode_reg;
      end
    end
  end

  assign prog_exc      = prog_exc_reg;
  assign prog_exc_tag  = prog_tag_reg;
  assign prog_exc_mode = prog_mode_reg;

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  always_comb begin
    irq_ev = '0;
    irq_ev[`FPX_IRQ_DELIVER]  = prog_exc_reg;
    irq_ev[`FPX_IRQ_ILLEGAL]  = illegal;
    irq_ev[`FPX_IRQ_SUPPRESS] = ex_suppress;
  end

  assign irq_w1c = (wr_acc && avs_address == `FPX_OFF_IRQ_STAT && avs_byteenable[0])
                 ? avs_writedata[`FPX_IRQ_W-1:0] : '0;

  // A new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_w1c) | irq_ev;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_mask_reg <= '0;
    end else if (wr_acc && avs_address == `FPX_OFF_IRQ_MASK && avs_byteenable[0]) begin
      irq_mask_reg <= avs_writedata[`FPX_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule

// >>> bench/fpx_exc_chk.sv
// Port checker of the exception unit
module fpx_exc_chk #(
  parameter int LAZY_CYCLES = 8
) (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic        ex_valid,
  input wire logic [12:0] ex_flags,
  input wire logic        ex_suppress,
  input wire logic        ex_write_result,
  input wire logic [4:0]  ex_trap_result,
  input wire logic        ex_hold_younger,
  input wire logic        prog_exc
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LAZY_MAX = LAZY_CYCLES + 4;
  logic [1:0] mode_sh;
  logic [4:0] en_sh;
  logic [4:0] tr_exp;
  logic       wr_ok;
  // ------------------------------
  // Shadow of mode and enables
  // ------------------------------
  // Assumes full-lane writes, which is all the bench issues
  assign wr_ok  = avs_write & ~avs_waitrequest;
  assign tr_exp = {|ex_flags[12:4], ex_flags[3:0]} & en_sh;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_sh <= 2'h0;
    end else if (wr_ok && avs_address == 5'h08) begin
      mode_sh <= avs_writedata[1:0];
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      en_sh <= 5'h00;
    end else if (wr_ok && avs_address == 5'h00) begin
      en_sh <= avs_writedata[20:16];
    end
  end
  // ------------------------------
  // Properties
  // ------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence s_prec_ev;
    ex_valid && |tr_exp && mode_sh == 2'h3;
  endsequence
  sequence s_impr_ev;
    ex_valid && |tr_exp && (mode_sh == 2'h1 || mode_sh == 2'h2);
  endsequence
  sequence s_pulse;
    prog_exc ##1 !prog_exc;
  endsequence
  wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Wait state longer than one cycle");
  idle_nowait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("Wait state without a request");
  suppress_val_a: assert property (ex_valid |-> ex_suppress == (tr_exp[4] | tr_exp[1]))
    else $error("Suppress does not match enabled invalid or zero-divide");
  result_wr_a: assert property (ex_write_result == (ex_valid && !ex_suppress))
    else $error("Result write does not follow suppress");
  trap_val_a: assert property (ex_valid |-> ex_trap_result == tr_exp)
    else $error("Trap result select wrong");
  precise_time_a: assert property (s_prec_ev |-> ##2 s_pulse)
    else $error("Precise delivery not two cycles after the instruction");
  hold_rec_a: assert property (ex_valid && |tr_exp && mode_sh[1] |-> ex_hold_younger)
    else $error("Younger instructions not held");
  hold_mode_a: assert property (ex_hold_younger |-> mode_sh[1])
    else $error("Hold raised in a mode without recovery");
  impr_bound_a: assert property (s_impr_ev |-> ##[1:LAZY_MAX] prog_exc)
    else $error("Imprecise delivery late");
  ignore_quiet_a: assert property ((mode_sh == 2'h0) [*3] |-> !prog_exc)
    else $error("Program exception in ignore mode");
  pulse_once_a: assert property (prog_exc |=> !prog_exc)
    else $error("Program exception longer than one cycle");
endmodule

bind fpx_exception_control fpx_exc_chk #(.LAZY_CYCLES(LAZY_CYCLES)) i_chk (
  .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .ex_valid(ex_valid), .ex_flags(ex_flags), .ex_suppress(ex_suppress),
  .ex_write_result(ex_write_result), .ex_trap_result(ex_trap_result),
  .ex_hold_younger(ex_hold_younger), .prog_exc(prog_exc)
);

// >>> bench/fpx_pipe_model.sv
// Arithmetic pipeline and program-exception side model
module fpx_pipe_model (
  input  wire logic        sys_clk,
  output logic             ex_valid,
  output logic [12:0]      ex_flags,
  output fpx_pkg::fpx_op_t ex_op,
  output logic [7:0]       ex_tag,
  output logic             sync_event,
  input  wire logic        ex_suppress,
  input  wire logic        ex_write_result,
  input  wire logic [4:0]  ex_trap_result,
  input  wire logic        ex_hold_younger,
  input  wire logic        prog_exc,
  input  wire logic [7:0]  prog_exc_tag,
  input  wire logic [1:0]  prog_exc_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  int         exc_cnt = 0;
  logic [7:0] last_tag = 8'h00;
  logic [1:0] last_mode = 2'h0;
  logic [7:0] seen;
  initial begin
    ex_valid = 1'b0;
    ex_flags = 13'h0000;
    ex_op = fpx_pkg::FPX_OP_OTHER;
    ex_tag = 8'h00;
    sync_event = 1'b0;
  end
  // Idle flag and tag lines show the inverse so stale values never look valid
  task automatic issue(input logic [12:0] f, input fpx_pkg::fpx_op_t o, input logic [7:0] t);
    @(posedge sys_clk);
    ex_valid <= 1'b1;
    ex_flags <= f;
    ex_op <= o;
    ex_tag <= t;
    #1;
    seen = {ex_hold_younger, ex_write_result, ex_suppress, ex_trap_result};
    @(posedge sys_clk);
    ex_valid <= 1'b0;
    ex_flags <= ~f;
    ex_tag <= ~t;
  endtask
  task automatic sync_pulse();
    @(posedge sys_clk);
    sync_event <= 1'b1;
    @(posedge sys_clk);
    sync_event <= 1'b0;
  endtask
  always @(negedge sys_clk) begin
    if (prog_exc === 1'b1) begin
      exc_cnt++;
      last_tag = prog_exc_tag;
      last_mode = prog_exc_mode;
    end
  end
endmodule

// >>> bench/fpx_exception_control_tb_top.sv
// Self-checking bench of the exception unit
`define TB_CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module fpx_exception_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LAZY = 40;
  logic             sys_clk;
  logic             rst;
  logic [4:0]       avs_address;
  logic             avs_read;
  logic             avs_write;
  logic [31:0]      avs_writedata;
  logic [3:0]       avs_byteenable;
  logic [31:0]      avs_readdata;
  logic             avs_waitrequest;
  logic             ex_valid;
  logic [12:0]      ex_flags;
  fpx_pkg::fpx_op_t ex_op;
  logic [7:0]       ex_tag;
  logic             sync_event;
  logic             ex_suppress;
  logic             ex_write_result;
  logic [4:0]       ex_trap_result;
  logic             ex_hold_younger;
  logic             prog_exc;
  logic [7:0]       prog_exc_tag;
  logic [1:0]       prog_exc_mode;
  logic             irq;
  int               err_total = 0;
  int               compares = 0;
  int               seed;
  int               i;
  int               n0;
  logic [31:0]      q;
  logic [4:0]       en;
  logic [4:0]       t;
  logic [12:0]      f;
  logic [12:0]      acc_f;
  logic [7:0]       etag = 8'h00;
  logic [12:0]      pair [4] = '{13'h0009, 13'h0110, 13'h0210, 13'h1010};
  fpx_exception_control #(.TAG_W(8), .LAZY_CYCLES(LAZY)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ex_valid(ex_valid),
    .ex_flags(ex_flags), .ex_op(ex_op), .ex_tag(ex_tag), .sync_event(sync_event),
    .ex_suppress(ex_suppress), .ex_write_result(ex_write_result),
    .ex_trap_result(ex_trap_result), .ex_hold_younger(ex_hold_younger),
    .prog_exc(prog_exc), .prog_exc_tag(prog_exc_tag), .prog_exc_mode(prog_exc_mode), .irq(irq)
  );
  fpx_pipe_model i_pipe (
    .sys_clk(sys_clk), .ex_valid(ex_valid), .ex_flags(ex_flags), .ex_op(ex_op),
    .ex_tag(ex_tag), .sync_event(sync_event), .ex_suppress(ex_suppress),
    .ex_write_result(ex_write_result), .ex_trap_result(ex_trap_result),
    .ex_hold_younger(ex_hold_younger), .prog_exc(prog_exc), .prog_exc_tag(prog_exc_tag),
    .prog_exc_mode(prog_exc_mode)
  );
  // ------------------------------
  // Expectations and bus access
  // ------------------------------
  function automatic logic [4:0] exp_trap(input logic [12:0] fl, input logic [4:0] e);
    return {|fl[12:4], fl[3:0]} & e;
  endfunction
  function automatic logic [31:0] exp_stat(input logic [12:0] fl, input logic [4:0] e);
    return {1'b1, |exp_trap(fl, e), |fl[12:4], 8'h00, e, 3'h0, fl};
  endfunction
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    // Read before this edge's updates land, so the sampled value
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    #400_000;
    err_total++;
    print_verdict();
  end
  // ------------------------------
  // Scenarios
  // ------------------------------
  initial begin
    seed = 32'h70f1;
    rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    for (i = 0; i < 7; i++) begin
      bus(1'b0, 5'(i * 4), 32'h0000_0000);
      `TB_CHK(q, (i == 5) ? 32'h0001_0000 : 32'h0000_0000)
    end
    acc_f = 13'h0000;
    for (i = 0; i < 12; i++) begin
      f = 13'h0001 << ($unsigned($random(seed)) % 13);
      i_pipe.issue(f, fpx_pkg::fpx_op_t'(2'($random(seed))), 8'(i));
      `TB_CHK(i_pipe.seen, 8'h40)
      acc_f = acc_f | f;
    end
    repeat (20) @(posedge sys_clk);
    bus(1'b0, 5'h00, 32'h0000_0000);
    `TB_CHK(q, exp_stat(acc_f, 5'h00))
    bus(1'b1, 5'h00, 32'h0000_0000);
    bus(1'b0, 5'h00, 32'h0000_0000);
    `TB_CHK(q, 32'h0000_0000)
    bus(1'b1, 5'h04, 32'h0000_0200);
    bus(1'b0, 5'h00, 32'h0000_0000);
    `TB_CHK(q, exp_stat(13'h0200, 5'h00))
    for (i = 0; i < 5; i++) begin
      i_pipe.issue((i < 4) ? pair[i] : 13'h000a, fpx_pkg::fpx_op_t'(i[1:0]), 8'h20);
      bus(1'b0, 5'h0c, 32'h0000_0000);
      `TB_CHK(q[1], (i == 4))
    end
    `TB_CHK(irq, 1'b0)
    bus(1'b1, 5'h10, 32'h0000_0002);
    @(negedge sys_clk);
    `TB_CHK(irq, 1'b1)
    bus(1'b1, 5'h0c, 32'h0000_0002);
    @(negedge sys_clk);
    `TB_CHK(irq, 1'b0)
    `TB_CHK(i_pipe.exc_cnt, 0)
    bus(1'b1, 5'h08, 32'h0000_0003);
    for (i = 0; i < 10; i++) begin
      en = (i == 0) ? 5'h1f : 5'($random(seed));
      f = (i < 4) ? pair[i] : 13'h0001 << ($unsigned($random(seed)) % 13);
      f = (i == 0) ? 13'h0002 : f;
      t = exp_trap(f, en);
      bus(1'b1, 5'h00, {11'h000, en, 16'h0000});
      n0 = i_pipe.exc_cnt;
      i_pipe.issue(f, fpx_pkg::fpx_op_t'(i[1:0]), 8'(8'h80 + i));
      `TB_CHK(i_pipe.seen, {|t, ~(t[4] | t[1]), t[4] | t[1], t})
      repeat (4) @(posedge sys_clk);
      `TB_CHK(i_pipe.exc_cnt, n0 + int'(|t))
      etag = (|t) ? 8'(8'h80 + i) : etag;
      `TB_CHK(i_pipe.last_tag, etag)
      bus(1'b0, 5'h00, 32'h0000_0000);
      `TB_CHK(q, exp_stat(f, en))
    end
    `TB_CHK(i_pipe.last_mode, 2'h3)
    for (i = 1; i < 4; i++) begin
      bus(1'b1, 5'h00, 32'h001f_0000);
      bus(1'b1, 5'h08, (i == 3) ? 32'h0000_0000 : 32'(i));
      n0 = i_pipe.exc_cnt;
      i_pipe.issue((i == 2) ? 13'h0008 : 13'h0002, fpx_pkg::FPX_OP_OTHER, 8'(8'h40 + i));
      `TB_CHK(i_pipe.seen[7], (i == 2))
      if (i == 2) begin
        i_pipe.sync_pulse();
      end else begin
        bus(1'b0, 5'h00, 32'h0000_0000);
      end
      repeat (6) @(posedge sys_clk);
      `TB_CHK(i_pipe.exc_cnt, n0 + int'(i < 3))
      `TB_CHK(i_pipe.last_tag, 8'(8'h40 + ((i < 3) ? i : 2)))
    end
    `TB_CHK(q, exp_stat(13'h0002, 5'h1f))
    bus(1'b1, 5'h08, 32'h0000_0002);
    bus(1'b1, 5'h00, 32'h001f_0000);
    n0 = i_pipe.exc_cnt;
    i_pipe.issue(13'h0001, fpx_pkg::FPX_OP_OTHER, 8'h55);
    repeat (LAZY + 6) @(posedge sys_clk);
    `TB_CHK(i_pipe.exc_cnt, n0 + 1)
    `TB_CHK(i_pipe.last_mode, 2'h2)
    print_verdict();
  end
endmodule
